/* arc_relay_top.sv */
/*
 * Alarm relay output controller: channel alarms, AND/OR combining,
 * delay counter, hold timers, N.O./N.C. polarity, APB registers, irq.
 * Assumes APB master synchronous to clk and readings synchronous to clk.
 */
// Function
// - hold new relay state for hold period
// - during hold ignore alarms, freeze counter
// - counter up on 1, down on 0
// - nonzero delay postpones change until reached
// - close delay enters, open delay leaves
// - open delay sets false time before release
// - under mode: set low, clear high
// - over mode: set high, clear low
// - closed and open hold minimum durations
// - zero delays switch in same evaluation
// - N.O. follows function, N.C. inverts
// - AND or OR of attached channels
// - channel source: alarm1, alarm2 or both
`timescale 1ns/1ps
module arc_relay_top #(
   parameter int TICK_CYCLES = arc_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [arc_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [arc_pkg::NCH*arc_pkg::DW-1:0] ch_reading,
   output logic relay_close,
   output logic irq
);
   import arc_pkg::*;

   // ==========================================================
   // configuration and state registers
   logic ctrl_and;
   logic ctrl_nc;
   logic [2*NCH-1:0] src_cfg;
   logic [DW-1:0] close_dly;
   logic [DW-1:0] open_dly;
   logic [DW-1:0] closed_hold;
   logic [DW-1:0] open_hold;
   logic [NCH-1:0] amode1;
   logic [NCH-1:0] amode2;
   logic [31:0] thr_mem [0:2*NCH-1];
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [TICK_CW-1:0] tick_cnt;
   logic tick;
   arc_relay_e rly_state;
   logic [DW-1:0] delay_cnt;
   logic [DW-1:0] hold_cnt;

   // ==========================================================
   // channel source selection
   function automatic logic chan_state(input logic [1:0] src, input logic a1,
      input logic a2);
      case (src)
         SRC_ALM1: chan_state = a1;
         SRC_ALM2: chan_state = a2;
         SRC_BOTH: chan_state = a1 & a2;
         default: chan_state = 1'b0;
      endcase
   endfunction

   logic [NCH-1:0] alm1_v;
   logic [NCH-1:0] alm2_v;
   logic [NCH-1:0] chan_in;
   logic [NCH-1:0] attached;

   // one comparator pair per channel
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      arc_chan_if cif();
      assign cif.reading = ch_reading[g*DW +: DW];
      assign cif.thr1 = thr_mem[2*g][HYST_LSB-1:0];
      assign cif.hyst1 = thr_mem[2*g][31:HYST_LSB];
      assign cif.thr2 = thr_mem[2*g+1][HYST_LSB-1:0];
      assign cif.hyst2 = thr_mem[2*g+1][31:HYST_LSB];
      assign cif.first_alarm_compare_mode = amode1[g];
      assign cif.second_alarm_compare_mode = amode2[g];
      assign alm1_v[g] = cif.alm1;
      assign alm2_v[g] = cif.alm2;
      assign chan_in[g] = chan_state(src_cfg[2*g +: 2], cif.alm1, cif.alm2);
      assign attached[g] = src_cfg[2*g +: 2] != SRC_NONE;
      arc_alarm_chan u_chan (
         .clk(clk),
         .rst(rst),
         .port(cif.chan)
      );
   end

   // combined function, zero when nothing is attached
   wire logic and_val = &(chan_in | ~attached);
   wire logic or_val = |(chan_in & attached);
   wire logic func = (|attached) & (ctrl_and ? and_val : or_val);

   // ==========================================================
   // timebase
   wire logic tick_wrap = tick_cnt == TICK_CW'(TICK_CYCLES - 1);

   // free running tenth-second divider
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
         tick <= tick_wrap;
      end
   end

   // ==========================================================
   // relay core: delay counter and hold timers
   wire logic holding = hold_cnt != '0;
   wire logic active = rly_state == RLY_ACTIVE;
   wire logic [DW-1:0] cnt_lim = active ? open_dly : close_dly;
   wire logic [DW-1:0] cnt_up = (delay_cnt < cnt_lim) ? delay_cnt + 1'b1 : cnt_lim;
   wire logic [DW-1:0] cnt_dn = (delay_cnt != '0) ? delay_cnt - 1'b1 : '0;
   wire logic close_reached = (close_dly == '0) || (delay_cnt + 1'b1 >= close_dly);

   arc_relay_e next_state;
   logic [DW-1:0] next_delay;
   logic [DW-1:0] next_hold;
   logic ev_close;
   logic ev_open;
   logic ev_hold;

   // state machine evaluated once per tick
   always_comb begin
      next_state = rly_state;
      next_delay = delay_cnt;
      next_hold = hold_cnt;
      ev_close = 1'b0;
      ev_open = 1'b0;
      ev_hold = 1'b0;
      if (tick && holding) begin
         next_hold = hold_cnt - 1'b1;
         ev_hold = hold_cnt == 16'h0001;
      end else if (tick) begin
         case (rly_state)
            RLY_IDLE: begin
               if (func && close_reached) begin
                  next_state = RLY_ACTIVE;
                  next_delay = open_dly;
                  next_hold = closed_hold;
                  ev_close = 1'b1;
               end else begin
                  next_delay = func ? cnt_up : cnt_dn;
               end
            end
            RLY_ACTIVE: begin
               if (!func && delay_cnt <= 16'h0001) begin
                  next_state = RLY_IDLE;
                  next_delay = '0;
                  next_hold = open_hold;
                  ev_open = 1'b1;
               end else begin
                  next_delay = func ? cnt_up : cnt_dn;
               end
            end
            default: begin
               next_state = RLY_IDLE;
               next_delay = '0;
            end
         endcase
      end
   end

   // relay core flops
   always_ff @(posedge clk) begin
      if (rst) begin
         rly_state <= RLY_IDLE;
         delay_cnt <= '0;
         hold_cnt <= '0;
         relay_close <= 1'b0;
      end else begin
         rly_state <= next_state;
         delay_cnt <= next_delay;
         hold_cnt <= next_hold;
         relay_close <= (next_state == RLY_ACTIVE) ^ ctrl_nc;
      end
   end

   // ==========================================================
   // apb decode
   wire logic acc = psel & penable;
   wire logic thr_hit = (paddr[7:5] == THR_REGION) && (paddr[1:0] == 2'h0);
   wire logic [2:0] thr_idx = paddr[4:2];
   wire logic addr_hit = thr_hit || paddr == OFS_CTRL || paddr == OFS_SRC
      || paddr == OFS_CLOSE_DLY || paddr == OFS_OPEN_DLY
      || paddr == OFS_CLOSED_HOLD || paddr == OFS_OPEN_HOLD
      || paddr == OFS_AMODE || paddr == OFS_STATUS || paddr == OFS_IRQ_STAT
      || paddr == OFS_IRQ_MASK || paddr == OFS_HOLD_CNT;
   wire logic wr_en = acc & pready & pwrite & addr_hit;
   wire logic [IRQ_W-1:0] irq_clr = (wr_en && paddr == OFS_IRQ_STAT) ?
      pwdata[IRQ_W-1:0] : '0;
   wire logic [IRQ_W-1:0] irq_ev = {ev_hold, ev_open, ev_close};
   wire logic [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
   wire logic [31:0] status_word = {delay_cnt, 4'h0, alm2_v, alm1_v, active,
      holding, func, relay_close};

   // read data selection
   wire logic [31:0] rd_val =
      thr_hit ? thr_mem[thr_idx] :
      (paddr == OFS_CTRL) ? {30'h0, ctrl_nc, ctrl_and} :
      (paddr == OFS_SRC) ? {24'h0, src_cfg} :
      (paddr == OFS_CLOSE_DLY) ? {16'h0, close_dly} :
      (paddr == OFS_OPEN_DLY) ? {16'h0, open_dly} :
      (paddr == OFS_CLOSED_HOLD) ? {16'h0, closed_hold} :
      (paddr == OFS_OPEN_HOLD) ? {16'h0, open_hold} :
      (paddr == OFS_AMODE) ? {24'h0, amode2, amode1} :
      (paddr == OFS_STATUS) ? status_word :
      (paddr == OFS_IRQ_STAT) ? {29'h0, irq_stat} :
      (paddr == OFS_IRQ_MASK) ? {29'h0, irq_mask} :
      (paddr == OFS_HOLD_CNT) ? {16'h0, hold_cnt} : 32'h00000000;

   // apb answer: one wait state, then pready for one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~addr_hit;
         prdata <= (acc & ~pready & ~pwrite) ? rd_val : 32'h00000000;
      end
   end

   // configuration writes
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_and <= 1'b0;
         ctrl_nc <= 1'b0;
         src_cfg <= RST_SRC;
         close_dly <= RST_TIME;
         open_dly <= RST_TIME;
         closed_hold <= RST_TIME;
         open_hold <= RST_TIME;
         amode1 <= '0;
         amode2 <= '0;
         irq_mask <= RST_IRQ;
      end else if (wr_en) begin
         case (paddr)
            OFS_CTRL: begin
               ctrl_and <= pwdata[CTRL_AND_BIT];
               ctrl_nc <= pwdata[CTRL_NC_BIT];
            end
            OFS_SRC: src_cfg <= pwdata[2*NCH-1:0];
            OFS_CLOSE_DLY: close_dly <= pwdata[DW-1:0];
            OFS_OPEN_DLY: open_dly <= pwdata[DW-1:0];
            OFS_CLOSED_HOLD: closed_hold <= pwdata[DW-1:0];
            OFS_OPEN_HOLD: open_hold <= pwdata[DW-1:0];
            OFS_AMODE: begin
               amode1 <= pwdata[NCH-1:0];
               amode2 <= pwdata[AMODE2_LSB +: NCH];
            end
            OFS_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // threshold and hysteresis words
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 2*NCH; i++) begin
            thr_mem[i] <= RST_THR;
         end
      end else if (wr_en && thr_hit) begin
         thr_mem[thr_idx] <= pwdata;
      end
   end

   // sticky events, set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat <= RST_IRQ;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq <= |(next_irq_stat & irq_mask);
      end
   end

   // ==========================================================
   // checks
   hold_freeze_a: assert property (@(posedge clk) disable iff (rst)
      tick && holding |=> delay_cnt == $past(delay_cnt) && rly_state == $past(rly_state))
      else $error("counter or state moved during hold");

   closed_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(active) |-> hold_cnt == $past(closed_hold))
      else $error("closed hold not loaded");

   open_hold_a: assert property (@(posedge clk) disable iff (rst)
      $fell(active) |-> hold_cnt == $past(open_hold))
      else $error("open hold not loaded");

   count_up_a: assert property (@(posedge clk) disable iff (rst)
      tick && !holding && !active && func && !close_reached
      |=> delay_cnt == $past(delay_cnt) + 16'h0001)
      else $error("delay counter did not count up");

   close_gate_a: assert property (@(posedge clk) disable iff (rst)
      $rose(active) |-> $past(tick) && $past(func)
      && ($past(close_dly) == 16'h0000 || $past(delay_cnt) + 17'h1 >= 17'($past(close_dly))))
      else $error("relay activated before close delay");

   release_gate_a: assert property (@(posedge clk) disable iff (rst)
      $fell(active) |-> $past(tick) && !$past(func) && $past(delay_cnt) <= 16'h0001)
      else $error("relay released before open delay");

   zero_delay_a: assert property (@(posedge clk) disable iff (rst)
      tick && !holding && close_dly == 16'h0000 && open_dly == 16'h0000
      && func != active |=> active == $past(func))
      else $error("zero delay switch not immediate");

   polarity_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> relay_close == (active ^ $past(ctrl_nc)))
      else $error("relay polarity wrong");

   tick_gap_a: assert property (@(posedge clk) disable iff (rst)
      tick |=> !tick)
      else $error("timebase ticked twice in a row");

   tick_only_a: assert property (@(posedge clk) disable iff (rst)
      !tick |=> delay_cnt == $past(delay_cnt) && hold_cnt == $past(hold_cnt))
      else $error("counter moved between ticks");

   count_down_a: assert property (@(posedge clk) disable iff (rst)
      tick && !holding && !func && delay_cnt > 16'h0001
      |=> delay_cnt == $past(delay_cnt) - 16'h0001)
      else $error("delay counter did not count down");

   irq_level_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> irq == |(irq_stat & $past(irq_mask)))
      else $error("interrupt level wrong");
endmodule

/* arc_pkg.sv */
/*
 * Shared constants for the alarm relay controller: register map,
 * field positions, reset values, source and state encodings, timebase.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
package arc_pkg;

   // ==========================================================
   // sizes
   localparam int NCH = 4;
   localparam int DW = 16;
   localparam int AW = 8;
   localparam int IRQ_W = 3;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SRC = 8'h04;
   localparam logic [7:0] OFS_CLOSE_DLY = 8'h08;
   localparam logic [7:0] OFS_OPEN_DLY = 8'h0C;
   localparam logic [7:0] OFS_CLOSED_HOLD = 8'h10;
   localparam logic [7:0] OFS_OPEN_HOLD = 8'h14;
   localparam logic [7:0] OFS_AMODE = 8'h18;
   localparam logic [2:0] THR_REGION = 3'h1;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h44;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
   localparam logic [7:0] OFS_HOLD_CNT = 8'h4C;

   // ==========================================================
   // field positions
   localparam int CTRL_AND_BIT = 0;
   localparam int CTRL_NC_BIT = 1;
   localparam int AMODE2_LSB = 4;
   localparam int HYST_LSB = 16;
   localparam int ST_RELAY_BIT = 0;
   localparam int ST_FUNC_BIT = 1;
   localparam int ST_HOLD_BIT = 2;
   localparam int ST_ACT_BIT = 3;
   localparam int ST_ALM_LSB = 4;
   localparam int ST_CNT_LSB = 16;
   localparam int IRQ_CLOSE_BIT = 0;
   localparam int IRQ_OPEN_BIT = 1;
   localparam int IRQ_HOLD_BIT = 2;

   // ==========================================================
   // reset values
   localparam logic [DW-1:0] RST_TIME = 16'h0000;
   localparam logic [2*NCH-1:0] RST_SRC = 8'h00;
   localparam logic [31:0] RST_THR = 32'h00000000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

   // ==========================================================
   // timebase: one tick per tenth of a second
   localparam longint TICK_NS = 100_000_000;
   localparam longint CLK_NS = 10;
   localparam int TICK_CYC = int'(TICK_NS / CLK_NS);
   localparam int TICK_CW = 24;

   // ==========================================================
   // encodings
   typedef enum logic [1:0] {SRC_NONE, SRC_ALM1, SRC_ALM2, SRC_BOTH} arc_src_e;
   typedef enum logic {RLY_IDLE, RLY_ACTIVE} arc_relay_e;

endpackage

/* arc_chan_if.sv */
/*
 * Per-channel bundle between the controller and one alarm comparator.
 * Assumes the controller drives reading and settings every cycle.
 */
`timescale 1ns/1ps
interface arc_chan_if;
   logic signed [15:0] reading;
   logic signed [15:0] thr1;
   logic signed [15:0] hyst1;
   logic signed [15:0] thr2;
   logic signed [15:0] hyst2;
   logic first_alarm_compare_mode;
   logic second_alarm_compare_mode;
   logic alm1;
   logic alm2;
   modport chan (input reading, thr1, hyst1, thr2, hyst2,
      first_alarm_compare_mode, second_alarm_compare_mode, output alm1, alm2);
   modport ctrl (output reading, thr1, hyst1, thr2, hyst2,
      first_alarm_compare_mode, second_alarm_compare_mode, input alm1, alm2);
endinterface

/* arc_alarm_chan.sv */
/*
 * Two hysteresis alarms of one measurement channel.
 * Assumes readings synchronous to clk; compare mode 1 = over, 0 = under.
 */
`timescale 1ns/1ps
module arc_alarm_chan (
   input wire logic clk,
   input wire logic rst,
   arc_chan_if.chan port
);
   import arc_pkg::*;

   // ==========================================================
   // hysteresis comparison
   function automatic logic next_alarm(input logic cur, input logic over,
      input logic signed [15:0] rd, input logic signed [15:0] thr,
      input logic signed [15:0] hyst);
      logic signed [17:0] hi;
      logic signed [17:0] lo;
      logic signed [17:0] r;
      hi = 18'(thr) + 18'(hyst);
      lo = 18'(thr) - 18'(hyst);
      r = 18'(rd);
      if (over) begin
         next_alarm = (r >= hi) ? 1'b1 : ((r <= lo) ? 1'b0 : cur);
      end else begin
         next_alarm = (r <= lo) ? 1'b1 : ((r >= hi) ? 1'b0 : cur);
      end
   endfunction

   wire logic next_alm1;
   wire logic next_alm2;
   assign next_alm1 = next_alarm(port.alm1, port.first_alarm_compare_mode,
      port.reading, port.thr1, port.hyst1);
   assign next_alm2 = next_alarm(port.alm2, port.second_alarm_compare_mode,
      port.reading, port.thr2, port.hyst2);

   // alarm state flops
   always_ff @(posedge clk) begin
      if (rst) begin
         port.alm1 <= 1'b0;
         port.alm2 <= 1'b0;
      end else begin
         port.alm1 <= next_alm1;
         port.alm2 <= next_alm2;
      end
   end

   // ==========================================================
   // checks
   over_set_a: assert property (@(posedge clk) disable iff (rst)
      port.first_alarm_compare_mode
      && (18'(port.reading) >= 18'(port.thr1) + 18'(port.hyst1)) |=> port.alm1)
      else $error("over alarm did not assert");
   under_set_a: assert property (@(posedge clk) disable iff (rst)
      !port.second_alarm_compare_mode
      && (18'(port.reading) <= 18'(port.thr2) - 18'(port.hyst2)) |=> port.alm2)
      else $error("under alarm did not assert");
endmodule

/* arc_relay_load.sv */
/*
 * Relay contact model switching an external load.
 * Assumes relay_close is a level synchronous to clk.
 */
`timescale 1ns/1ps
module arc_relay_load (
   input wire logic clk,
   input wire logic rst,
   input wire logic relay_close,
   output logic load_on
);
   // ==========================================================
   // contact settles one cycle after the coil command
   always_ff @(posedge clk) begin
      if (rst) begin
         load_on <= 1'b0;
      end else begin
         load_on <= relay_close;
      end
   end
endmodule

/* arc_relay_top_tb.sv */
/*
 * Self-checking bench for the alarm relay controller.
 * Assumes TICK_CYCLES of 8; the bus master waits for pready at rising edges.
 */
`timescale 1ns/1ps
module arc_relay_top_tb;
   import arc_pkg::*;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [NCH*DW-1:0] ch_reading = '0;
   logic [31:0] prdata;
   logic pready, pslverr, relay_close, irq, load_on;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   logic [31:0] q;
   logic e;

   arc_relay_top #(.TICK_CYCLES(8)) arc_relay_top_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ch_reading(ch_reading),
      .relay_close(relay_close), .irq(irq));
   arc_relay_load arc_relay_load_inst (.clk(clk), .rst(rst), .relay_close(relay_close),
      .load_on(load_on));

   // ==========================================================
   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 20000) begin
         mismatches++;
         finish_test();
      end
   end

   // ==========================================================
   // report and compare
   task automatic finish_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ==========================================================
   // bus, stimulus and wait helpers
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request stands until pready is seen high at a rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set_rd(input int ch, input logic [15:0] v);
      @(posedge clk);
      ch_reading[16*ch +: 16] <= v;
   endtask
   task automatic wait_relay(input logic v, input int lim);
      n = 0;
      while (relay_close !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic cfg(input logic [31:0] c, s, cd, od, chd, oh, am);
      apb(1'b1, OFS_SRC, s);
      apb(1'b1, OFS_AMODE, am);
      apb(1'b1, OFS_CLOSE_DLY, cd);
      apb(1'b1, OFS_OPEN_DLY, od);
      apb(1'b1, OFS_CLOSED_HOLD, chd);
      apb(1'b1, OFS_OPEN_HOLD, oh);
      apb(1'b1, OFS_CTRL, c);
   endtask

   // ==========================================================
   // scenarios
   task automatic s_reset;
      check1("relay after reset", 1'b0, relay_close);
      apb(1'b0, OFS_STATUS, 0);
      check32("status reset", 32'h00000FF0, q);
      apb(1'b0, 8'h80, 0);
      check1("unmapped error", 1'b1, e);
      check32("unmapped data", 32'h00000000, q);
   endtask
   task automatic s_over;
      apb(1'b1, 8'h20, {16'h0001, 16'h000A});
      apb(1'b1, OFS_AMODE, 32'h1);
      cfg(0, 32'h1, 0, 0, 0, 0, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      set_rd(0, 16'h000A);
      repeat (24) @(posedge clk);
      check1("below high stays open", 1'b0, relay_close);
      check1("no irq before close", 1'b0, irq);
      set_rd(0, 16'h000B);
      wait_relay(1'b1, 12);
      check1("over closes", 1'b1, relay_close);
      check1("irq on close", 1'b1, irq);
      set_rd(0, 16'h000A);
      repeat (24) @(posedge clk);
      check1("hysteresis keeps", 1'b1, relay_close);
      set_rd(0, 16'h0009);
      wait_relay(1'b0, 12);
      check1("over clears", 1'b0, relay_close);
      apb(1'b0, OFS_IRQ_STAT, 0);
      check32("irq status", 32'h00000003, q);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      @(negedge clk);
      check1("irq cleared", 1'b0, irq);
      apb(1'b0, OFS_IRQ_STAT, 0);
      check32("irq status left", 32'h00000002, q);
   endtask
   task automatic s_under;
      set_rd(1, 16'h001E);
      cfg(0, 32'h8, 0, 0, 0, 0, 32'h0);
      apb(1'b1, 8'h2C, {16'h0002, 16'h0014});
      set_rd(1, 16'h0013);
      repeat (24) @(posedge clk);
      check1("above low stays open", 1'b0, relay_close);
      set_rd(1, 16'h0012);
      wait_relay(1'b1, 12);
      check1("under closes", 1'b1, relay_close);
      set_rd(1, 16'h0015);
      repeat (24) @(posedge clk);
      check1("under hysteresis", 1'b1, relay_close);
      set_rd(1, 16'h0016);
      wait_relay(1'b0, 12);
      check1("under clears", 1'b0, relay_close);
   endtask
   task automatic s_and_nc;
      apb(1'b1, OFS_SRC, 32'h0);
      apb(1'b1, OFS_AMODE, 32'hFF);
      set_rd(0, 16'h0000);
      set_rd(1, 16'h0005);
      apb(1'b1, 8'h20, {16'h0000, 16'h000A});
      apb(1'b1, 8'h24, {16'h0000, 16'h0014});
      apb(1'b1, 8'h28, {16'h0000, 16'h000A});
      cfg(32'h3, 32'h7, 0, 0, 0, 0, 32'hFF);
      wait_relay(1'b1, 12);
      check1("inverted idle closed", 1'b1, relay_close);
      set_rd(1, 16'h000F);
      set_rd(0, 16'h000F);
      repeat (24) @(posedge clk);
      check1("one alarm of both", 1'b1, relay_close);
      set_rd(0, 16'h0019);
      wait_relay(1'b0, 12);
      check1("all attached open", 1'b0, relay_close);
      set_rd(1, 16'h0005);
      wait_relay(1'b1, 12);
      check1("and drops", 1'b1, relay_close);
   endtask
   task automatic s_delay;
      set_rd(0, 16'h0000);
      apb(1'b1, 8'h20, {16'h0001, 16'h000A});
      cfg(0, 32'h1, 3, 2, 0, 0, 32'h1);
      set_rd(0, 16'h000B);
      repeat (12) @(posedge clk);
      apb(1'b0, OFS_STATUS, 0);
      check1("count up", 1'b1, q[31:16] inside {16'h1, 16'h2});
      check1("still open", 1'b0, q[0]);
      set_rd(0, 16'h0000);
      repeat (32) @(posedge clk);
      apb(1'b0, OFS_STATUS, 0);
      check32("count down", 32'h00000000, {16'h0000, q[31:16]});
      set_rd(0, 16'h000B);
      wait_relay(1'b1, 28);
      check1("close after delay", 1'b1, relay_close);
      check1("close not early", 1'b1, n > 16);
      set_rd(0, 16'h0000);
      wait_relay(1'b0, 20);
      check1("open after delay", 1'b0, relay_close);
      check1("open not early", 1'b1, n > 8);
   endtask
   task automatic s_hold;
      cfg(0, 32'h1, 0, 0, 4, 3, 32'h1);
      set_rd(0, 16'h000B);
      wait_relay(1'b1, 12);
      set_rd(0, 16'h0000);
      wait_relay(1'b0, 60);
      check1("closed hold", 1'b1, n >= 32);
      set_rd(0, 16'h000B);
      wait_relay(1'b1, 60);
      check1("open hold", 1'b1, n >= 24);
      check1("closed end", 1'b1, relay_close);
      @(negedge clk);
      check1("load follows", 1'b1, load_on);
      apb(1'b0, OFS_IRQ_STAT, 0);
      check1("hold elapsed flag", 1'b1, q[2]);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_over();
      s_under();
      s_and_nc();
      s_delay();
      s_hold();
      finish_test();
   end
endmodule
